/* design/its_defines.svh */
/*
  Offsets, field positions, reset values and vectors of the interrupt and
  trap sequencer.
  Assumes inclusion by bare name from any design or bench file.
*/
`ifndef ITS_DEFINES_SVH
`define ITS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ITS_OFS_CTRL     8'h00
`define ITS_OFS_STATUS   8'h04
`define ITS_OFS_IRQ_STAT 8'h08
`define ITS_OFS_IRQ_MASK 8'h0c
`define ITS_OFS_PC       8'h10
`define ITS_OFS_SP       8'h14
`define ITS_OFS_PSW      8'h18

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ITS_CTRL_RUN_BIT 0
`define ITS_CTRL_RESET   1'b1
`define ITS_PSW_PRI_HI   7
`define ITS_PSW_PRI_LO   5
`define ITS_PSW_TRACE    4
`define ITS_PSW_RESET    16'h0000
`define ITS_SP_RESET     16'h0000
`define ITS_PC_RESET     16'h0000
`define ITS_EV_ERR       0
`define ITS_EV_TRACE     1
`define ITS_EV_DEV       2
`define ITS_EV_WAIT      3
`define ITS_LVL_BASE     3'h4

// ----------------------------------------------------------------------
// Vectors, step and I/O page
// ----------------------------------------------------------------------
`define ITS_VEC_ERR      16'h0004
`define ITS_VEC_TRACE    16'h000c
`define ITS_VEC_PFAIL    16'h0014
`define ITS_PC_PWRUP     16'h0014
`define ITS_WORD_STEP    16'h0002
`define ITS_IO_BASE      16'he000

`endif

/* design/its_pkg.sv */
/*
  Types shared by the interrupt and trap sequencer and its bench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package its_pkg;

  typedef enum logic [3:0] {
    ST_POWERUP  = 4'h0,
    ST_BOUNDARY = 4'h1,
    ST_FETCH    = 4'h2,
    ST_EXEC     = 4'h3,
    ST_WAIT     = 4'h4,
    ST_OFF      = 4'h5,
    ST_PUSH_PS  = 4'h6,
    ST_PUSH_PC  = 4'h7,
    ST_LOAD_PC  = 4'h8,
    ST_LOAD_PS  = 4'h9
  } its_state_t;

  typedef enum logic [2:0] {
    CA_NONE  = 3'h0,
    CA_BOUND = 3'h1,
    CA_TMO   = 3'h2,
    CA_PFAIL = 3'h3,
    CA_TRACE = 3'h4,
    CA_DEV   = 3'h5
  } its_cause_t;

  typedef struct packed {
    logic        we;
    logic        io;
    logic [15:0] addr;
    logic [15:0] wdata;
  } its_mem_req_t;

endpackage

/* design/its_req_encoder.sv */
/*
  Synchronises device request pins, merges them into four level lines and
  picks the winning device and its vector.
  Assumes level and vector inputs are static configuration.
*/
`timescale 1ns/1ps
`include "its_defines.svh"

module its_req_encoder #(
  parameter int NDEV = 4
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Device side
  input  wire logic [NDEV-1:0]      dev_req_i,
  input  wire logic [NDEV-1:0][1:0] dev_level_i,
  input  wire logic [NDEV-1:0][15:0] dev_vector_i,
  // Encoded result
  output logic      [3:0]           bus_request_levels_o,
  output logic      [2:0]           req_level_o,
  output logic                      req_any_o,
  output logic      [NDEV-1:0]      req_sel_o,
  output logic      [15:0]          req_vector_o
);

  logic [NDEV-1:0] s1_reg;
  logic [NDEV-1:0] s2_reg;
  logic [NDEV-1:0] s3_reg;
  logic [NDEV-1:0] filt_reg;
  logic [3:0][NDEV-1:0] hit;
  logic [1:0] top;

  if (NDEV < 1) begin : g_chk
    $error("NDEV must be at least 1");
  end

  // --------------------------------------------------------------------
  // Pin synchroniser, change taken once stages two and three agree
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg   <= dev_req_i;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) |
                  (filt_reg & (s2_reg ^ s3_reg));
    end
  end

  // --------------------------------------------------------------------
  // Level lines: OR of every device pending on that level
  // --------------------------------------------------------------------
  for (genvar l = 0; l < 4; l++) begin : g_lvl
    for (genvar d = 0; d < NDEV; d++) begin : g_dev
      assign hit[l][d] = filt_reg[d] && (dev_level_i[d] == 2'(l));
    end
    assign bus_request_levels_o[l] = |hit[l];
  end

  // --------------------------------------------------------------------
  // Highest level first, lowest device index within it
  // --------------------------------------------------------------------
  always_comb begin
    top = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (bus_request_levels_o[l]) begin
        top = 2'(l);
      end
    end
    req_any_o    = |bus_request_levels_o;
    req_level_o  = `ITS_LVL_BASE + {1'b0, top};
    req_sel_o    = '0;
    req_vector_o = 16'h0000;
    for (int d = NDEV - 1; d >= 0; d--) begin
      if (hit[top][d]) begin
        req_sel_o    = '0;
        req_sel_o[d] = 1'b1;
        req_vector_o = dev_vector_i[d];
      end
    end
  end

  a_top_level: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_request_levels_o[3] |-> req_level_o == 3'h7)
    else $error("level seven request not encoded as seven");

endmodule // its_req_encoder

/* design/its_sequencer.sv */
/*
  Interrupt and trap sequencer: fetch and execute hand-off, context switch
  through vectors, trace, error, power-fail and power-up handling, with a
  classic Wishbone register slave.
  Assumes a word memory port that answers with a one-cycle ack and an
  execution unit that pulses done once per started instruction.
*/
`timescale 1ns/1ps
`include "its_defines.svh"

module its_sequencer #(
  parameter int NDEV = 4
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Devices
  input  wire logic [NDEV-1:0]       dev_req_i,
  input  wire logic [NDEV-1:0][1:0]  dev_level_i,
  input  wire logic [NDEV-1:0][15:0] dev_vector_i,
  output logic      [NDEV-1:0]       dev_grant_o,
  // Error events
  input  wire logic                  boundary_err_i,
  input  wire logic                  bus_timeout_i,
  input  wire logic                  power_fail_i,
  // Memory port
  output logic                       mem_req_o,
  output its_pkg::its_mem_req_t      mem_o,
  input  wire logic [15:0]           mem_rdata_i,
  input  wire logic                  mem_ack_i,
  // Execution unit
  output logic                       exec_start_o,
  output logic      [15:0]           exec_instr_o,
  input  wire logic                  exec_done_i,
  input  wire logic                  exec_wait_i,
  // Interrupt
  output logic                       irq_o
);

  if (NDEV < 1 || NDEV > 32) begin : g_chk
    $error("NDEV must lie between 1 and 32");
  end

  its_pkg::its_state_t   state_reg;
  its_pkg::its_cause_t   cause_reg;
  its_pkg::its_cause_t   sw_cause;
  its_pkg::its_mem_req_t mem_reg;
  logic [15:0] pc_reg, sp_reg, psw_reg, vec_reg, ir_reg, sw_vec;
  logic [2:0]  new_pri_reg, req_level;
  logic [3:0]  bus_request_levels, stat_reg, mask_reg, ev;
  logic [NDEV-1:0] req_sel, grant_reg;
  logic [15:0] req_vector;
  logic req_any, interrupt_pending, start_sw, run_reg, trace_due_reg;
  logic bnd_reg, tmo_reg, pf_reg, start_reg, ack_reg;
  logic pf1_reg, pf2_reg, pf3_reg, pf_filt_reg;
  logic [31:0] dat_reg, rd_mux;
  logic wb_req, wb_wr, in_mem;

  function automatic its_pkg::its_mem_req_t mk_req(
    input logic we, input logic [15:0] addr, input logic [15:0] wdata);
    its_pkg::its_mem_req_t r;
    r.we    = we;
    r.io    = (addr >= `ITS_IO_BASE);
    r.addr  = addr;
    r.wdata = wdata;
    return r;
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------------
  // Request combining and priority test
  // ----------------------------------------------------------------------
  // Devices are trusted to sit on one level each.
  its_req_encoder #(.NDEV(NDEV)) u_its_req_encoder (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .dev_req_i            (dev_req_i),
    .dev_level_i          (dev_level_i),
    .dev_vector_i         (dev_vector_i),
    .bus_request_levels_o (bus_request_levels),
    .req_level_o          (req_level),
    .req_any_o            (req_any),
    .req_sel_o            (req_sel),
    .req_vector_o         (req_vector)
  );

  assign interrupt_pending = req_any &&
    (req_level >= psw_reg[`ITS_PSW_PRI_HI:`ITS_PSW_PRI_LO]);

  // ----------------------------------------------------------------------
  // Boundary arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    sw_cause = its_pkg::CA_NONE;
    sw_vec   = 16'h0000;
    if (bnd_reg) begin
      sw_cause = its_pkg::CA_BOUND;
      sw_vec   = `ITS_VEC_ERR;
    end else if (tmo_reg) begin
      sw_cause = its_pkg::CA_TMO;
      sw_vec   = `ITS_VEC_ERR;
    end else if (pf_reg) begin
      sw_cause = its_pkg::CA_PFAIL;
      sw_vec   = `ITS_VEC_PFAIL;
    end else if (trace_due_reg) begin
      sw_cause = its_pkg::CA_TRACE;
      sw_vec   = `ITS_VEC_TRACE;
    end else if (interrupt_pending && run_reg) begin
      sw_cause = its_pkg::CA_DEV;
      sw_vec   = req_vector;
    end
  end

  assign start_sw = (sw_cause != its_pkg::CA_NONE) &&
                    (state_reg == its_pkg::ST_BOUNDARY ||
                     state_reg == its_pkg::ST_WAIT);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= its_pkg::ST_POWERUP;
      cause_reg     <= its_pkg::CA_NONE;
      mem_reg       <= '0;
      pc_reg        <= `ITS_PC_RESET;
      sp_reg        <= `ITS_SP_RESET;
      psw_reg       <= `ITS_PSW_RESET;
      vec_reg       <= 16'h0000;
      ir_reg        <= 16'h0000;
      new_pri_reg   <= 3'h0;
      trace_due_reg <= 1'b0;
      start_reg     <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wb_wr && wb_adr_i == `ITS_OFS_PC)
        pc_reg <= merge16(pc_reg, wb_dat_i, wb_sel_i);
      if (wb_wr && wb_adr_i == `ITS_OFS_SP)
        sp_reg <= merge16(sp_reg, wb_dat_i, wb_sel_i);
      if (wb_wr && wb_adr_i == `ITS_OFS_PSW)
        psw_reg <= merge16(psw_reg, wb_dat_i, wb_sel_i);
      if (start_sw) begin
        sp_reg      <= sp_reg - `ITS_WORD_STEP;
        mem_reg     <= mk_req(1'b1, sp_reg - `ITS_WORD_STEP, psw_reg);
        vec_reg     <= sw_vec;
        cause_reg   <= sw_cause;
        new_pri_reg <= req_level;
        state_reg   <= its_pkg::ST_PUSH_PS;
        if (sw_cause == its_pkg::CA_TRACE) trace_due_reg <= 1'b0;
      end else begin
        case (state_reg)
          its_pkg::ST_POWERUP: begin
            pc_reg        <= `ITS_PC_PWRUP;
            trace_due_reg <= 1'b0;
            state_reg     <= its_pkg::ST_BOUNDARY;
          end
          its_pkg::ST_BOUNDARY: begin
            if (!run_reg) begin
              state_reg <= its_pkg::ST_OFF;
            end else begin
              mem_reg   <= mk_req(1'b0, pc_reg, 16'h0000);
              state_reg <= its_pkg::ST_FETCH;
            end
          end
          its_pkg::ST_FETCH: if (mem_ack_i) begin
            ir_reg    <= mem_rdata_i;
            pc_reg    <= pc_reg + `ITS_WORD_STEP;
            start_reg <= 1'b1;
            state_reg <= its_pkg::ST_EXEC;
          end
          its_pkg::ST_EXEC: if (exec_done_i) begin
            trace_due_reg <= psw_reg[`ITS_PSW_TRACE] &&
                             !exec_wait_i;
            state_reg <= exec_wait_i ? its_pkg::ST_WAIT : its_pkg::ST_BOUNDARY;
          end
          its_pkg::ST_WAIT: state_reg <= its_pkg::ST_WAIT;
          its_pkg::ST_OFF: if (run_reg) state_reg <= its_pkg::ST_BOUNDARY;
          its_pkg::ST_PUSH_PS: if (mem_ack_i) begin
            sp_reg    <= sp_reg - `ITS_WORD_STEP;
            mem_reg   <= mk_req(1'b1, sp_reg - `ITS_WORD_STEP, pc_reg);
            state_reg <= its_pkg::ST_PUSH_PC;
          end
          its_pkg::ST_PUSH_PC: if (mem_ack_i) begin
            mem_reg   <= mk_req(1'b0, vec_reg, 16'h0000);
            state_reg <= its_pkg::ST_LOAD_PC;
          end
          its_pkg::ST_LOAD_PC: if (mem_ack_i) begin
            pc_reg    <= mem_rdata_i;
            mem_reg   <= mk_req(1'b0, vec_reg + `ITS_WORD_STEP, 16'h0000);
            state_reg <= its_pkg::ST_LOAD_PS;
          end
          its_pkg::ST_LOAD_PS: if (mem_ack_i) begin
            psw_reg <= mem_rdata_i;
            if (cause_reg == its_pkg::CA_DEV) begin
              psw_reg[`ITS_PSW_PRI_HI:`ITS_PSW_PRI_LO] <= new_pri_reg;
            end
            if (cause_reg == its_pkg::CA_TRACE) begin
              psw_reg[`ITS_PSW_TRACE] <= 1'b0;
            end
            state_reg <= its_pkg::ST_BOUNDARY;
          end
          default: state_reg <= its_pkg::ST_POWERUP;
        endcase
      end
    end
  end

  assign in_mem = state_reg inside {its_pkg::ST_FETCH, its_pkg::ST_PUSH_PS,
    its_pkg::ST_PUSH_PC, its_pkg::ST_LOAD_PC, its_pkg::ST_LOAD_PS};
  assign mem_req_o    = in_mem;
  assign mem_o        = mem_reg;
  assign exec_start_o = start_reg;
  assign exec_instr_o = ir_reg;

  // ----------------------------------------------------------------------
  // Error flags and power-fail pin
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pf1_reg, pf2_reg, pf3_reg, pf_filt_reg} <= 4'h0;
      {bnd_reg, tmo_reg, pf_reg} <= 3'h0;
      grant_reg <= '0;
    end else begin
      pf1_reg <= power_fail_i;
      pf2_reg <= pf1_reg;
      pf3_reg <= pf2_reg;
      if (pf2_reg == pf3_reg) pf_filt_reg <= pf3_reg;
      bnd_reg <= boundary_err_i ||
        (bnd_reg && !(start_sw && sw_cause == its_pkg::CA_BOUND));
      tmo_reg <= bus_timeout_i ||
        (tmo_reg && !(start_sw && sw_cause == its_pkg::CA_TMO));
      pf_reg <= (pf3_reg && !pf_filt_reg && pf2_reg == pf3_reg) ||
        (pf_reg && !(start_sw && sw_cause == its_pkg::CA_PFAIL));
      grant_reg <= (start_sw && sw_cause == its_pkg::CA_DEV) ? req_sel : '0;
    end
  end
  assign dev_grant_o = grant_reg;

  // ----------------------------------------------------------------------
  // Wishbone slave and interrupt status
  // ----------------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr  = wb_req && wb_we_i;
  assign ev[`ITS_EV_ERR]   = start_sw && sw_cause inside
    {its_pkg::CA_BOUND, its_pkg::CA_TMO, its_pkg::CA_PFAIL};
  assign ev[`ITS_EV_TRACE] = start_sw && sw_cause == its_pkg::CA_TRACE;
  assign ev[`ITS_EV_DEV]   = start_sw && sw_cause == its_pkg::CA_DEV;
  assign ev[`ITS_EV_WAIT]  = state_reg == its_pkg::ST_EXEC &&
                             exec_done_i && exec_wait_i;

  always_comb begin
    case (wb_adr_i)
      `ITS_OFS_CTRL:     rd_mux = {31'h0, run_reg};
      `ITS_OFS_STATUS:   rd_mux = {17'h0, tmo_reg, bnd_reg, pf_reg,
                                   bus_request_levels, interrupt_pending,
                                   req_level, state_reg};
      `ITS_OFS_IRQ_STAT: rd_mux = {28'h0, stat_reg};
      `ITS_OFS_IRQ_MASK: rd_mux = {28'h0, mask_reg};
      `ITS_OFS_PC:       rd_mux = {16'h0, pc_reg};
      `ITS_OFS_SP:       rd_mux = {16'h0, sp_reg};
      `ITS_OFS_PSW:      rd_mux = {16'h0, psw_reg};
      default:           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h0;
      run_reg  <= `ITS_CTRL_RESET;
      mask_reg <= 4'h0;
      stat_reg <= 4'h0;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) dat_reg <= wb_we_i ? 32'h0 : rd_mux;
      if (wb_wr && wb_adr_i == `ITS_OFS_CTRL && wb_sel_i[0])
        run_reg <= wb_dat_i[`ITS_CTRL_RUN_BIT];
      if (wb_wr && wb_adr_i == `ITS_OFS_IRQ_MASK && wb_sel_i[0])
        mask_reg <= wb_dat_i[3:0];
      // Set wins over a write-one clear in the same cycle
      stat_reg <= ev | (stat_reg & ~((wb_wr && wb_sel_i[0] &&
        wb_adr_i == `ITS_OFS_IRQ_STAT) ? wb_dat_i[3:0] : 4'h0));
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_powerup_pc: assert property ($fell(rst_i) |=> ##1
    pc_reg == 16'h0014)
    else $error("power-up did not load counter 24 octal");
  a_fetch_step: assert property (state_reg == its_pkg::ST_FETCH && mem_ack_i
    |=> pc_reg == $past(pc_reg) + 16'h0002 && exec_start_o)
    else $error("fetch did not advance counter by two");
  a_push_pair: assert property (state_reg == its_pkg::ST_PUSH_PS && mem_ack_i
    |=> mem_o.we && mem_o.wdata == pc_reg && mem_o.addr == sp_reg &&
        sp_reg == $past(sp_reg) - 16'h0002)
    else $error("counter push not two below status");
  a_bound_vec: assert property (start_sw && bnd_reg
    |=> vec_reg == 16'h0004 && cause_reg == its_pkg::CA_BOUND)
    else $error("boundary error not vectored to 4 octal");
  a_tmo_vec: assert property (start_sw && tmo_reg && !bnd_reg
    |=> vec_reg == 16'h0004 && !tmo_reg)
    else $error("time-out not vectored or not cleared");
  a_pfail_vec: assert property (start_sw && sw_cause == its_pkg::CA_PFAIL
    |=> vec_reg == 16'h0014)
    else $error("power-fail not vectored to 24 octal");
  a_trace_clear: assert property (state_reg == its_pkg::ST_LOAD_PS &&
    mem_ack_i && cause_reg == its_pkg::CA_TRACE
    |=> !psw_reg[4] && state_reg == its_pkg::ST_BOUNDARY)
    else $error("trace flag survived trace trap");
  a_dev_prio: assert property (state_reg == its_pkg::ST_LOAD_PS &&
    mem_ack_i && cause_reg == its_pkg::CA_DEV
    |=> psw_reg[7:5] == $past(new_pri_reg))
    else $error("priority not set to accepted level");
  a_err_first: assert property (start_sw && trace_due_reg && tmo_reg
    |-> sw_cause == its_pkg::CA_TMO)
    else $error("trace served before error");
  a_wait_idle: assert property (state_reg == its_pkg::ST_WAIT &&
    sw_cause == its_pkg::CA_NONE |=> state_reg == its_pkg::ST_WAIT &&
    !mem_req_o)
    else $error("activity in wait without request");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  c_dev_int: cover property (ev[`ITS_EV_DEV] ##[1:20] irq_o);
  c_trace:   cover property (ev[`ITS_EV_TRACE]);
  c_wait_wake: cover property (state_reg == its_pkg::ST_WAIT ##1
    state_reg == its_pkg::ST_PUSH_PS);
  c_pfail:   cover property (ev[`ITS_EV_ERR] && pf_reg);

endmodule // its_sequencer

/* dv/its_dev_model.sv */
/*
  Model of one device controller that raises an interrupt request.
  Assumes a grant pulse from the sequencer for each accepted request.
*/
`timescale 1ns/1ps
module its_dev_model #(
  parameter logic EN = 1'b1
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Handshake
  input  wire logic done_i,
  input  wire logic grant_i,
  output logic      req_o
);
  logic done_reg;
  // Done stays set until the grant takes it
  always_ff @(posedge clk_i) begin
    if (rst_i || grant_i) done_reg <= 1'b0;
    else if (done_i) done_reg <= 1'b1;
  end
  assign req_o = done_reg & EN;
endmodule // its_dev_model

/* dv/interrupt_trap_sequencer_bench.sv */
/*
  Self-checking bench of the interrupt and trap sequencer.
  Assumes the memory answers every access one cycle later.
*/
`timescale 1ns/1ps
module interrupt_trap_sequencer_bench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic bnd = 0, tmo = 0, pf = 0, mack = 0, dn = 0, wt = 0;
  logic wmode = 0, fire = 0, pw = 0, lio = 0, ack, mreq, st, irq, dreq;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, rd, q;
  logic [3:0]  gnt;
  logic [15:0] rdat = 0, ins, vec = 0, lwa = 0, f1 = 16'hffff;
  logic [40:0] rows [5] = '{{1'b0, 8'h0c, 32'h0}, {1'b1, 8'h0c, 32'hf},
    {1'b0, 8'h0c, 32'hf}, {1'b0, 8'h1c, 32'h0}, {1'b0, 8'h00, 32'h1}};
  its_pkg::its_mem_req_t mo;
  int n_errors = 0, comparisons = 0, cyc_n = 0;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  its_sequencer #(.NDEV(4)) u_its_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .dev_req_i({3'h0, dreq}), .dev_level_i({6'h0, 2'h1}),
    .dev_vector_i({48'h0, 16'h0040}), .dev_grant_o(gnt),
    .boundary_err_i(bnd), .bus_timeout_i(tmo), .power_fail_i(pf),
    .mem_req_o(mreq), .mem_o(mo), .mem_rdata_i(rdat), .mem_ack_i(mack),
    .exec_start_o(st), .exec_instr_o(ins), .exec_done_i(dn),
    .exec_wait_i(wt), .irq_o(irq));
  its_dev_model u_its_dev_model (.clk_i(clk_i), .rst_i(rst_i),
    .done_i(fire), .grant_i(gnt[0]), .req_o(dreq));

  // Memory, execution unit and hang guard
  always @(posedge clk_i) begin
    mack <= mreq & ~mack;
    // Trace vector status word has trace set, so the trap must clear it
    rdat <= (mo.addr == 16'h000e) ? 16'h0010 : 16'h2000;
    dn <= st;
    wt <= st & wmode;
    cyc_n <= cyc_n + 1;
    if (mack && f1 == 16'hffff) f1 <= mo.addr;
    if (mack && mo.we) begin
      lwa <= mo.addr;
      lio <= mo.io;
    end
    if (mack && pw && !mo.we) vec <= mo.addr;
    if (mack) pw <= mo.we;
    if (cyc_n == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  // k selects the pulse: bit0 boundary, bit1 time-out, bit2 device done
  task automatic pulse_wait(input logic [2:0] k);
    {fire, tmo, bnd} <= k;
    @(posedge clk_i);
    {fire, tmo, bnd} <= 3'h0;
    repeat (60) @(posedge clk_i);
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(f1, 16'h0014);
    chk(ins, 16'h2000);
    foreach (rows[i]) begin
      wb(rows[i][40], rows[i][39:32], rows[i][31:0]);
      if (!rows[i][40]) chk(q, rows[i][31:0]);
    end
    $display("register rows done");
    pulse_wait(3'h1);
    chk(vec, 16'h0004);
    chk(lwa, 16'hfffc);
    chk(lio, 1'b1);
    chk(irq, 1'b1);
    wb(1'b1, 8'h08, 32'hf);
    chk(irq, 1'b0);
    wb(1'b1, 8'h18, 32'h10);
    repeat (60) @(posedge clk_i);
    chk(vec, 16'h000c);
    wb(1'b0, 8'h18, 32'h0);
    chk(q[4], 1'b0);
    pulse_wait(3'h2);
    chk(vec, 16'h0004);
    pf <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk(vec, 16'h0014);
    $display("trap tests done");
    wb(1'b1, 8'h18, 32'hc0);
    pulse_wait(3'h4);
    chk(vec, 16'h0014);
    wb(1'b1, 8'h18, 32'ha0);
    repeat (60) @(posedge clk_i);
    chk(vec, 16'h0040);
    wb(1'b0, 8'h18, 32'h0);
    chk(q[7:5], 3'h5);
    chk(dreq, 1'b0);
    $display("device test done");
    wmode <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[3:0], 4'h4);
    repeat (20) begin
      @(posedge clk_i);
      chk(mreq, 1'b0);
    end
    $display("wait test done");
    end_sim();
  end
endmodule // interrupt_trap_sequencer_bench
